/* rfsd_consts.vh */
// constants and bit layout of the rf status display register bank
`ifndef RFSD_CONSTS_VH
`define RFSD_CONSTS_VH

// register offsets
`define RFSD_OFS_COLL 6'h20
`define RFSD_OFS_TSTATE 6'h21
`define RFSD_OFS_TXLEN_HI 6'h22
`define RFSD_OFS_TXLEN_LO 6'h23
`define RFSD_OFS_RATE 6'h24
`define RFSD_OFS_ADC 6'h25

// reset values
`define RFSD_RST_BYTE 8'h00
`define RFSD_RST_TXLEN 13'h0000
`define RFSD_RST_XBITS 3'h0

// collision register fields
`define RFSD_COLL_BYTE_MSB 7
`define RFSD_COLL_BYTE_LSB 4
`define RFSD_COLL_BIT_MSB 3
`define RFSD_COLL_BIT_LSB 1
`define RFSD_COLL_PAR_POS 0

// tx length low register fields
`define RFSD_TXLO_CNT_MSB 7
`define RFSD_TXLO_CNT_LSB 3
`define RFSD_TXLO_XB_MSB 2
`define RFSD_TXLO_XB_LSB 0

// rate register fields
`define RFSD_RATE_MSB 5
`define RFSD_RATE_LSB 4

// passive target state codes
`define RFSD_TS_POWER_OFF 4'h0
`define RFSD_TS_IDLE 4'h1
`define RFSD_TS_READY1 4'h2
`define RFSD_TS_READY2 4'h3
`define RFSD_TS_ACTIVE 4'h5
`define RFSD_TS_HALT 4'h9
`define RFSD_TS_READY1_STAR 4'hA
`define RFSD_TS_READY2_STAR 4'hB
`define RFSD_TS_ACTIVE_STAR 4'hD

`endif

/* rfsd_regs.v */
// rf status display register bank with transmit length registers
`include "rfsd_consts.vh"

module rfsd_regs #(
  parameter ADDR_W = 6
) (
  // clock, reset, enable
  input wire clk_i,
  input wire rstn_i,
  input wire ce_i,
  // host register port
  input wire [ADDR_W-1:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [7:0] rdata_o,
  // receiver collision reports
  input wire frame_start_i,
  input wire coll_event_i,
  input wire coll_in_anticoll_i,
  input wire [3:0] coll_bytes_i,
  input wire [2:0] coll_bits_i,
  input wire coll_parity_i,
  input wire hard_framing_error_i,
  output wire hard_framing_error_flag_o,
  // passive target state machine
  input wire [3:0] target_state_i,
  output wire target_active_o,
  // bit rate detection and timers
  input wire rate_detect_mode_i,
  input wire rate_valid_i,
  input wire [1:0] rate_code_i,
  input wire field_on_guard2_running_i,
  input wire gp_timer_running_i,
  input wire no_resp_timer_running_i,
  input wire mask_rx_timer_running_i,
  // converter
  input wire adc_done_i,
  input wire [7:0] adc_data_i,
  // transmitter
  input wire [7:0] tx_last_byte_i,
  output wire [12:0] tx_full_bytes_o,
  output wire [2:0] tx_extra_bits_o,
  output wire tx_split_byte_o,
  output wire tx_no_parity_o,
  output wire [7:0] tx_last_bits_o,
  // direct commands
  input wire anticoll_ctrl_i,
  input wire card_idle_i,
  input wire reqa_cmd_i,
  input wire wupa_cmd_i,
  output reg parity_error_irq_o
);

  // masks the unsent upper bits of a split byte; bits leave lsb first
  function [7:0] rfsd_low_mask;
    input [2:0] nbits;
    begin
      if (nbits == 3'h0)
      begin
        rfsd_low_mask = 8'hFF;
      end
      else
      begin
        rfsd_low_mask = ~(8'hFF << nbits);
      end
    end
  endfunction

  // true when the address hits a given register offset
  function rfsd_hit;
    input [ADDR_W-1:0] a;
    input [5:0] ofs;
    begin
      rfsd_hit = (a == ofs);
    end
  endfunction

  // state registers
  reg [3:0] coll_bytes_reg;
  reg [3:0] coll_bytes_next;
  reg [2:0] coll_bits_reg;
  reg [2:0] coll_bits_next;
  reg coll_par_reg;
  reg coll_par_next;
  reg coll_seen_reg;
  reg coll_seen_next;
  reg hard_err_reg;
  reg hard_err_next;
  reg [3:0] tstate_reg;
  reg [1:0] rate_reg;
  reg [1:0] rate_next;
  reg [3:0] timers_reg;
  reg [7:0] adc_reg;
  reg [7:0] adc_next;
  reg [12:0] txlen_reg;
  reg [12:0] txlen_next;
  reg [2:0] xbits_reg;
  reg [2:0] xbits_next;
  reg [7:0] rdata_next;
  reg par_irq_next;
  reg [7:0] last_bits_reg;
  reg [7:0] last_bits_next;

  // decoded host strobes and the collision capture strobe
  wire wr_hi;
  wire wr_lo;
  wire coll_take;

  assign wr_hi = wr_i & rfsd_hit(addr_i, `RFSD_OFS_TXLEN_HI);
  assign wr_lo = wr_i & rfsd_hit(addr_i, `RFSD_OFS_TXLEN_LO);

  // only the first collision of a frame, and only inside anticollision length
  assign coll_take = coll_event_i & coll_in_anticoll_i & (~coll_seen_reg | frame_start_i);

  // collision position capture
  always @*
  begin
    coll_bytes_next = coll_bytes_reg;
    coll_bits_next = coll_bits_reg;
    coll_par_next = coll_par_reg;
    if (coll_take)
    begin
      coll_bytes_next = coll_bytes_i;
      coll_bits_next = coll_bits_i;
      coll_par_next = coll_parity_i;
    end
  end

  // first-collision tracker; a collision in the start cycle still counts
  always @*
  begin
    coll_seen_next = coll_seen_reg;
    if (frame_start_i)
    begin
      coll_seen_next = 1'b0;
    end
    if (coll_event_i & coll_in_anticoll_i)
    begin
      coll_seen_next = 1'b1;
    end
  end

  // hard framing error flag; a new error wins over the frame-start clear
  always @*
  begin
    hard_err_next = hard_err_reg;
    if (frame_start_i)
    begin
      hard_err_next = 1'b0;
    end
    if (hard_framing_error_i)
    begin
      hard_err_next = 1'b1;
    end
  end

  // bit rate code only updates in detection target mode
  always @*
  begin
    rate_next = rate_reg;
    if (rate_detect_mode_i & rate_valid_i)
    begin
      rate_next = rate_code_i;
    end
  end

  // converter result held between conversions
  always @*
  begin
    adc_next = adc_reg;
    if (adc_done_i)
    begin
      adc_next = adc_data_i;
    end
  end

  // transmit length registers, the only host-writable storage
  always @*
  begin
    txlen_next = txlen_reg;
    xbits_next = xbits_reg;
    if (wr_hi)
    begin
      txlen_next[12:5] = wdata_i;
    end
    if (wr_lo)
    begin
      txlen_next[4:0] = wdata_i[`RFSD_TXLO_CNT_MSB:`RFSD_TXLO_CNT_LSB];
      xbits_next = wdata_i[`RFSD_TXLO_XB_MSB:`RFSD_TXLO_XB_LSB];
    end
  end

  // parity error pulse on REQA or WUPA under anticollision with extra bits
  always @*
  begin
    par_irq_next = anticoll_ctrl_i & card_idle_i & (xbits_reg != `RFSD_RST_XBITS)
      & (reqa_cmd_i | wupa_cmd_i);
  end

  // read mux; data stands only in the cycle after the read strobe
  always @*
  begin
    rdata_next = `RFSD_RST_BYTE;
    if (rd_i)
    begin
      case (addr_i)
        `RFSD_OFS_COLL:
        begin
          rdata_next = {coll_bytes_reg, coll_bits_reg, coll_par_reg};
        end
        `RFSD_OFS_TSTATE:
        begin
          rdata_next = {4'h0, tstate_reg};
        end
        `RFSD_OFS_TXLEN_HI:
        begin
          rdata_next = txlen_reg[12:5];
        end
        `RFSD_OFS_TXLEN_LO:
        begin
          rdata_next = {txlen_reg[4:0], xbits_reg};
        end
        `RFSD_OFS_RATE:
        begin
          rdata_next = {2'h0, rate_reg, timers_reg};
        end
        `RFSD_OFS_ADC:
        begin
          rdata_next = adc_reg;
        end
        default:
        begin
          rdata_next = `RFSD_RST_BYTE;
        end
      endcase
    end
  end

  // collision and error state; host writes never reach these
  always @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      coll_bytes_reg <= 4'h0;
      coll_bits_reg <= 3'h0;
      coll_par_reg <= 1'b0;
      coll_seen_reg <= 1'b0;
      hard_err_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      coll_bytes_reg <= coll_bytes_next;
      coll_bits_reg <= coll_bits_next;
      coll_par_reg <= coll_par_next;
      coll_seen_reg <= coll_seen_next;
      hard_err_reg <= hard_err_next;
    end
  end

  // display state sampled from the device logic
  always @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      tstate_reg <= `RFSD_TS_POWER_OFF;
      rate_reg <= 2'h0;
      timers_reg <= 4'h0;
      adc_reg <= `RFSD_RST_BYTE;
    end
    else if (ce_i)
    begin
      tstate_reg <= target_state_i;
      rate_reg <= rate_next;
      timers_reg <= {field_on_guard2_running_i, gp_timer_running_i,
        no_resp_timer_running_i, mask_rx_timer_running_i};
      adc_reg <= adc_next;
    end
  end

  // transmit length storage
  always @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      txlen_reg <= `RFSD_RST_TXLEN;
      xbits_reg <= `RFSD_RST_XBITS;
    end
    else if (ce_i)
    begin
      txlen_reg <= txlen_next;
      xbits_reg <= xbits_next;
    end
  end

  // host read data and command pulse
  always @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      rdata_o <= `RFSD_RST_BYTE;
      parity_error_irq_o <= 1'b0;
    end
    else if (ce_i)
    begin
      rdata_o <= rdata_next;
      parity_error_irq_o <= par_irq_next;
    end
  end

  // split-byte bits; only the low extra bits leave, lsb first
  always @*
  begin
    last_bits_next = tx_last_byte_i & rfsd_low_mask(xbits_reg);
  end

  // split-byte bits held in a flop so the transmitter sees a settled value
  always @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      last_bits_reg <= `RFSD_RST_BYTE;
    end
    else if (ce_i)
    begin
      last_bits_reg <= last_bits_next;
    end
  end

  // transmitter view of the length and split-byte handling
  assign tx_full_bytes_o = txlen_reg;
  assign tx_extra_bits_o = xbits_reg;
  assign tx_split_byte_o = (xbits_reg != `RFSD_RST_XBITS);
  assign tx_no_parity_o = tx_split_byte_o;
  assign tx_last_bits_o = last_bits_reg;

  // status levels for the rest of the device
  assign hard_framing_error_flag_o = hard_err_reg;
  assign target_active_o = (tstate_reg == `RFSD_TS_ACTIVE) |
    (tstate_reg == `RFSD_TS_ACTIVE_STAR);

endmodule

/* rfsd_regs_properties.sv */
// checker for the rf status display register bank ports
module rfsd_regs_properties (
  input wire clk_i, rstn_i, ce_i, wr_i, rd_i,
  input wire [5:0] addr_i,
  input wire [7:0] wdata_i, rdata_o,
  input wire [12:0] tx_full_bytes_o,
  input wire [2:0] tx_extra_bits_o,
  input wire tx_split_byte_o, tx_no_parity_o, anticoll_ctrl_i, card_idle_i,
  input wire reqa_cmd_i, wupa_cmd_i, parity_error_irq_o,
  input wire [3:0] target_state_i,
  input wire target_active_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // read data stand only in the cycle after a read
  property p_rd_idle;
    ce_i && !rd_i |=> rdata_o == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read");
  property p_txhi;
    ce_i && wr_i && addr_i == 6'h22 |=> tx_full_bytes_o[12:5] == $past(wdata_i);
  endproperty
  a_txhi: assert property (p_txhi) else $error("high count not loaded");
  property p_txlo;
    ce_i && wr_i && addr_i == 6'h23 |=> tx_full_bytes_o[4:0] == $past(wdata_i[7:3]);
  endproperty
  a_txlo: assert property (p_txlo) else $error("low count not loaded");
  property p_xbits;
    ce_i && wr_i && addr_i == 6'h23 |=> tx_extra_bits_o == $past(wdata_i[2:0]);
  endproperty
  a_xbits: assert property (p_xbits) else $error("extra bits not loaded");
  property p_split;
    tx_split_byte_o == (tx_extra_bits_o != 3'h0) && tx_no_parity_o == tx_split_byte_o;
  endproperty
  a_split: assert property (p_split) else $error("split byte flags wrong");
  property p_irq;
    ce_i && anticoll_ctrl_i && card_idle_i && tx_extra_bits_o != 3'h0
      && (reqa_cmd_i || wupa_cmd_i) |=> parity_error_irq_o;
  endproperty
  a_irq: assert property (p_irq) else $error("parity interrupt missing");
  property p_irq_cause;
    parity_error_irq_o && $past(ce_i) |-> $past(reqa_cmd_i || wupa_cmd_i);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("parity interrupt unprompted");
  property p_active;
    ce_i |=> target_active_o == ($past(target_state_i) inside {4'h5, 4'hD});
  endproperty
  a_active: assert property (p_active) else $error("active flag wrong");
endmodule
bind rfsd_regs rfsd_regs_properties CHK (.*);

/* rfsd_host.sv */
// host model driving the register port
module rfsd_host (
  input wire clk_i,
  output logic [5:0] addr_o,
  output logic [7:0] wdata_o,
  output logic wr_o, rd_o,
  input wire [7:0] rdata_i
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {addr_o, wdata_o, wr_o, rd_o} = '0;
  // one-cycle write; a 13-bit count never exceeds 8191
  task wr(input logic [5:0] a, input logic [7:0] dt);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= dt;
    wr_o <= 1'h1;
    @(posedge clk_i);
    wr_o <= 1'h0;
    #1;
  endtask
  // one-cycle read, data taken in the following cycle
  task rd(input logic [5:0] a, output logic [7:0] dt);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'h1;
    @(posedge clk_i);
    rd_o <= 1'h0;
    #1 dt = rdata_i;
  endtask
endmodule

/* rfsd_regs_tb.sv */
// self-checking bench for the rf status display register bank
module rfsd_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 0, rstn_i = 0, ce_i = 1, frame_start_i = 0, coll_event_i = 0;
  logic coll_in_anticoll_i = 0, coll_parity_i = 0, hard_framing_error_i = 0;
  logic rate_detect_mode_i = 0, rate_valid_i = 0, adc_done_i = 0, anticoll_ctrl_i = 0;
  logic field_on_guard2_running_i = 0, gp_timer_running_i = 0, no_resp_timer_running_i = 0;
  logic mask_rx_timer_running_i = 0, card_idle_i = 0, reqa_cmd_i = 0, wupa_cmd_i = 0;
  logic [3:0] coll_bytes_i = 0, target_state_i = 0;
  logic [2:0] coll_bits_i = 0, tx_extra_bits_o;
  logic [1:0] rate_code_i = 0;
  logic [7:0] adc_data_i = 0, tx_last_byte_i = 0, wdata_i, rdata_o, tx_last_bits_o, d;
  logic [5:0] addr_i;
  logic wr_i, rd_i, hard_framing_error_flag_o, target_active_o, tx_split_byte_o;
  logic tx_no_parity_o, parity_error_irq_o;
  logic [12:0] tx_full_bytes_o;
  logic [3:0] codes [9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h5, 4'h9, 4'hA, 4'hB, 4'hD};
  int fail_count = 0, samples_checked = 0;
  rfsd_regs DUT (.*);
  rfsd_host HOST (.clk_i(clk_i), .addr_o(addr_i), .wdata_o(wdata_i), .wr_o(wr_i),
    .rd_o(rd_i), .rdata_i(rdata_o));
  // clock of 50 ns period
  initial forever #25 clk_i = ~clk_i;
  task chk(input logic [12:0] seen, input logic [12:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task close_out;
    if (fail_count == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // full count boundary, split byte, low register read-back and an unmapped place
  task t_txlen;
    HOST.wr(6'h22, 8'hFF);
    HOST.wr(6'h23, 8'hFB);
    tx_last_byte_i <= 8'hA5;
    chk(tx_full_bytes_o, 13'h1FFF);
    @(posedge clk_i);
    #1 chk(tx_last_bits_o, 8'h05);
    chk(tx_no_parity_o, 1'h1);
    HOST.rd(6'h23, d);
    chk(d, 8'hFB);
    HOST.wr(6'h23, 8'h00);
    @(posedge clk_i);
    #1 chk(tx_last_bits_o, 8'hA5);
    chk(tx_split_byte_o, 1'h0);
    HOST.rd(6'h26, d);
    chk(d, 8'h00);
  endtask
  // first collision kept, later and out-of-range ones dropped
  task t_coll;
    @(posedge clk_i);
    {frame_start_i, coll_in_anticoll_i} <= 2'h3;
    @(posedge clk_i);
    {frame_start_i, coll_event_i, coll_parity_i} <= 3'h3;
    {coll_bytes_i, coll_bits_i} <= 7'h1D;
    @(posedge clk_i);
    coll_bytes_i <= 4'h7;
    @(posedge clk_i);
    coll_event_i <= 1'h0;
    HOST.wr(6'h20, 8'h00);
    HOST.rd(6'h20, d);
    chk(d, 8'h3B);
    @(posedge clk_i);
    {frame_start_i, coll_in_anticoll_i} <= 2'h2;
    @(posedge clk_i);
    {frame_start_i, coll_event_i} <= 2'h1;
    @(posedge clk_i);
    coll_event_i <= 1'h0;
    HOST.rd(6'h20, d);
    chk(d, 8'h3B);
    {frame_start_i, hard_framing_error_i} <= 2'h3;
    @(posedge clk_i);
    {frame_start_i, hard_framing_error_i} <= 2'h0;
    #1 chk(hard_framing_error_flag_o, 1'h1);
  endtask
  // every target state code read back
  task t_state;
    foreach (codes[i])
    begin
      @(posedge clk_i);
      target_state_i <= codes[i];
      HOST.rd(6'h21, d);
      chk(d, {4'h0, codes[i]});
      chk(target_active_o, codes[i] == 4'h5 || codes[i] == 4'hD);
    end
  endtask
  // rate latched on valid, timers, converter result held
  task t_rate_adc;
    @(posedge clk_i);
    {rate_detect_mode_i, rate_valid_i, rate_code_i, adc_done_i} <= 5'h1D;
    {field_on_guard2_running_i, no_resp_timer_running_i, adc_data_i} <= 10'h35C;
    @(posedge clk_i);
    {rate_valid_i, rate_code_i, adc_done_i, adc_data_i} <= 12'h211;
    HOST.rd(6'h24, d);
    chk(d, 8'h2A);
    HOST.rd(6'h25, d);
    chk(d, 8'h5C);
  endtask
  // parity interrupt on both commands, none without extra bits
  task t_irq;
    HOST.wr(6'h23, 8'h01);
    {anticoll_ctrl_i, card_idle_i, reqa_cmd_i} <= 3'h7;
    @(posedge clk_i);
    {reqa_cmd_i, wupa_cmd_i} <= 2'h1;
    #1 chk(parity_error_irq_o, 1'h1);
    @(posedge clk_i);
    wupa_cmd_i <= 1'h0;
    #1 chk(parity_error_irq_o, 1'h1);
    HOST.wr(6'h23, 8'h00);
    reqa_cmd_i <= 1'h1;
    @(posedge clk_i);
    reqa_cmd_i <= 1'h0;
    #1 chk(parity_error_irq_o, 1'h0);
  endtask
  // clock enable low freezes storage; a mid-run reset clears it again
  task t_freeze;
    @(posedge clk_i);
    ce_i <= 1'h0;
    HOST.wr(6'h22, 8'h12);
    chk(tx_full_bytes_o, 13'h1FE0);
    @(posedge clk_i);
    {ce_i, rstn_i} <= 2'h2;
    @(posedge clk_i);
    rstn_i <= 1'h1;
    #1 chk(tx_full_bytes_o, 13'h0000);
    chk(hard_framing_error_flag_o, 1'h0);
  endtask
  initial
  begin
    repeat (20) @(posedge clk_i);
    rstn_i <= 1'h1;
    t_txlen;
    t_coll;
    t_state;
    t_rate_adc;
    t_irq;
    t_freeze;
    close_out;
  end
  // watchdog far beyond the hundred or so cycles needed
  initial
  begin
    #100000;
    fail_count++;
    close_out;
  end
endmodule
